// ### hdl/tgss_pkg.sv
// Package of offsets, fields and reset values for the timer gate source select block
package tgss_pkg;

	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int CNT_W  = 16;
	localparam int PER_W  = 8;

	// Register offsets
	localparam logic [ADDR_W-1:0] OFS_GATE_CTRL  = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_PERIOD     = 4'h1;
	localparam logic [ADDR_W-1:0] OFS_PER_COUNT  = 4'h2;
	localparam logic [ADDR_W-1:0] OFS_CMP_STATUS = 4'h3;
	localparam logic [ADDR_W-1:0] OFS_CNT_LO     = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_CNT_HI     = 4'h5;

	// Field positions
	localparam int GSS_LSB  = 0;
	localparam int GSS_MSB  = 1;
	localparam int GPOL_BIT = 6;
	localparam int CMP1_BIT = 6;
	localparam int CMP2_BIT = 7;

	// Gate source select codes
	localparam logic [1:0] GSS_PIN   = 2'h0;
	localparam logic [1:0] GSS_MATCH = 2'h1;
	localparam logic [1:0] GSS_CMP1  = 2'h2;
	localparam logic [1:0] GSS_CMP2  = 2'h3;

	// Reset values
	localparam logic [1:0]       RST_GSS    = 2'h0;
	localparam logic             RST_GPOL   = 1'b0;
	localparam logic [PER_W-1:0] RST_PERIOD = 8'hFF;
	localparam logic [PER_W-1:0] RST_PCOUNT = 8'h00;
	localparam logic [CNT_W-1:0] RST_COUNT  = 16'h0000;
	localparam logic [DATA_W-1:0] RST_RDATA = 8'h00;

endpackage

// ### hdl/tgss_gate_timer.sv
// Gate source selection, polarity, period timer and gated counter
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
// Function
// [R01] Two-bit select routes one of four gate sources
// [R02] Polarity bit six clear inverts chosen gate source; set passes it unchanged
// [R03] Period timer wraps to zero after match
// [R04] Wrap makes one-cycle high match pulse; with period zero the pulse stays high
// [R05] Match source, polarity one: count after match
// [R06] Match source, polarity zero: skip after match
// [R07] Comparator one status bit six gates counter
// [R08] Comparator two status bit seven gates counter
// [R09] Pin source passes gate pin level through
// [R10] Counter advances only when sampled gate enabled
module tgss_gate_timer
	import tgss_pkg::*;
(
	input  wire logic              core_clk_i,
	input  wire logic              rstn_i,
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic [DATA_W-1:0] wr_data_i,
	input  wire logic              wr_i,
	input  wire logic              rd_i,
	input  wire logic              gate_input_pin_i,
	input  wire logic              comparator_one_out_i,
	input  wire logic              comparator_two_out_i,
	output logic [DATA_W-1:0]      rd_data_o,
	output logic [CNT_W-1:0]       count_o,
	output logic                   gate_enable_o,
	output logic                   match_pulse_o
);

	////////////////////////////////////////////////////////////////////////////
	// Declarations

	logic [1:0]        gate_source_select_q;
	logic              gate_polarity_q;
	logic [PER_W-1:0]  period_value_q;
	logic [PER_W-1:0]  period_timer_count_q;
	logic [PER_W-1:0]  period_timer_count_d;
	logic              match_pulse_q;
	logic [CNT_W-1:0]  count_q;
	logic [CNT_W-1:0]  count_d;
	logic              gate_en_q;
	logic [DATA_W-1:0] rd_data_q;
	logic [DATA_W-1:0] rd_data_d;
	logic              pin_s1_q;
	logic              pin_s2_q;
	logic              cmp1_s1_q;
	logic              cmp1_s2_q;
	logic              cmp2_s1_q;
	logic              cmp2_s2_q;

	wire               wr_ctrl;
	wire               wr_period;
	wire               wr_cnt_lo;
	wire               wr_cnt_hi;
	wire               cnt_wr;
	wire               period_match;
	wire               gate_src;
	wire               gate_en;
	wire [DATA_W-1:0]  gate_control_reg;
	wire [DATA_W-1:0]  comparator_status_reg;
	wire [DATA_W-1:0]  rd_mux;

	////////////////////////////////////////////////////////////////////////////
	// Address decode

	assign wr_ctrl   = wr_i && (addr_i == OFS_GATE_CTRL);
	assign wr_period = wr_i && (addr_i == OFS_PERIOD);
	assign wr_cnt_lo = wr_i && (addr_i == OFS_CNT_LO);
	assign wr_cnt_hi = wr_i && (addr_i == OFS_CNT_HI);
	assign cnt_wr    = wr_cnt_lo || wr_cnt_hi;

	assign gate_control_reg = {1'b0, gate_polarity_q, 4'h0, gate_source_select_q};
	assign comparator_status_reg = {cmp2_s2_q, cmp1_s2_q, 6'h00};

	assign rd_mux = (addr_i == OFS_GATE_CTRL)  ? gate_control_reg :
	                (addr_i == OFS_PERIOD)     ? period_value_q :
	                (addr_i == OFS_PER_COUNT)  ? period_timer_count_q :
	                (addr_i == OFS_CMP_STATUS) ? comparator_status_reg :
	                (addr_i == OFS_CNT_LO)     ? count_q[7:0] :
	                (addr_i == OFS_CNT_HI)     ? count_q[15:8] :
	                RST_RDATA;
	assign rd_data_d = rd_i ? rd_mux : RST_RDATA;

	////////////////////////////////////////////////////////////////////////////
	// Input synchronisers

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pin_s1_q  <= 1'b0;
			pin_s2_q  <= 1'b0;
			cmp1_s1_q <= 1'b0;
			cmp1_s2_q <= 1'b0;
			cmp2_s1_q <= 1'b0;
			cmp2_s2_q <= 1'b0;
		end else begin
			pin_s1_q  <= gate_input_pin_i;
			pin_s2_q  <= pin_s1_q;
			cmp1_s1_q <= comparator_one_out_i;
			cmp1_s2_q <= cmp1_s1_q;
			cmp2_s1_q <= comparator_two_out_i;
			cmp2_s2_q <= cmp2_s1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Control registers

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			gate_source_select_q <= RST_GSS;
			gate_polarity_q      <= RST_GPOL;
			period_value_q       <= RST_PERIOD;
			rd_data_q            <= RST_RDATA;
		end else begin
			if (wr_ctrl) begin
				gate_source_select_q <= wr_data_i[GSS_MSB:GSS_LSB];
				gate_polarity_q      <= wr_data_i[GPOL_BIT];
			end
			if (wr_period) begin
				period_value_q <= wr_data_i;
			end
			rd_data_q <= rd_data_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Period timer and match pulse

	assign period_match = (period_timer_count_q == period_value_q);
	assign period_timer_count_d = period_match ? RST_PCOUNT :  // R03
	                              period_timer_count_q + 8'h01;

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			period_timer_count_q <= RST_PCOUNT;
			match_pulse_q        <= 1'b0;
		end else begin
			period_timer_count_q <= period_timer_count_d;
			match_pulse_q        <= period_match;  // R04
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Gate selection and counter

	// R01 R09 R07 R08
	assign gate_src = (gate_source_select_q == GSS_PIN)   ? pin_s2_q :
	                  (gate_source_select_q == GSS_MATCH) ? match_pulse_q :
	                  (gate_source_select_q == GSS_CMP1)  ? comparator_status_reg[CMP1_BIT] :
	                  comparator_status_reg[CMP2_BIT];
	// R02 R05 R06
	assign gate_en = gate_polarity_q ? gate_src : !gate_src;

	// Software write takes the count over an increment
	assign count_d = wr_cnt_lo ? {count_q[15:8], wr_data_i} :
	                 wr_cnt_hi ? {wr_data_i, count_q[7:0]} :
	                 gate_en   ? count_q + 16'h0001 :  // R10
	                 count_q;

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			count_q   <= RST_COUNT;
			gate_en_q <= 1'b0;
		end else begin
			count_q   <= count_d;
			gate_en_q <= gate_en;
		end
	end

	assign rd_data_o     = rd_data_q;
	assign count_o       = count_q;
	assign gate_enable_o = gate_en_q;
	assign match_pulse_o = match_pulse_q;

	////////////////////////////////////////////////////////////////////////////
	// Assertions

	a_sel_pin_path: assert property (  // R09
		@(posedge core_clk_i) disable iff (!rstn_i)
		(gate_source_select_q == GSS_PIN && $past(rstn_i, 2))
		|-> (gate_src == $past(gate_input_pin_i, 2)))
		else $error("pin source not routed");

	a_sel_match_path: assert property (  // R01
		@(posedge core_clk_i) disable iff (!rstn_i)
		(gate_source_select_q == GSS_MATCH) |-> (gate_src == $past(period_match)))
		else $error("match source not routed");

	a_sel_cmp_one: assert property (  // R07
		@(posedge core_clk_i) disable iff (!rstn_i)
		(gate_source_select_q == GSS_CMP1 && $past(rstn_i, 2))
		|-> (gate_src == $past(comparator_one_out_i, 2)))
		else $error("comparator one not routed");

	a_sel_cmp_two: assert property (  // R08
		@(posedge core_clk_i) disable iff (!rstn_i)
		(gate_source_select_q == GSS_CMP2 && $past(rstn_i, 2))
		|-> (gate_src == $past(comparator_two_out_i, 2)))
		else $error("comparator two not routed");

	a_pol_applied: assert property (  // R02
		@(posedge core_clk_i) disable iff (!rstn_i)
		$past(rstn_i) |-> (gate_enable_o == $past(gate_polarity_q ? gate_src : !gate_src)))
		else $error("polarity not applied");

	a_timer_wrap: assert property (  // R03
		@(posedge core_clk_i) disable iff (!rstn_i)
		(period_timer_count_q == period_value_q) |=> (period_timer_count_q == 8'h00))
		else $error("period timer did not wrap");

	a_timer_step: assert property (  // R03
		@(posedge core_clk_i) disable iff (!rstn_i)
		(rstn_i && period_timer_count_q != period_value_q)
		|=> (period_timer_count_q == $past(period_timer_count_q) + 8'h01))
		else $error("period timer did not step");

	a_pulse_width: assert property (  // R04
		@(posedge core_clk_i) disable iff (!rstn_i)
		(period_match && period_value_q != 8'h00 && !wr_period)
		|=> match_pulse_o ##1 !match_pulse_o)
		else $error("match pulse not one cycle");

	a_match_pol_one: assert property (  // R05
		@(posedge core_clk_i) disable iff (!rstn_i)
		(gate_source_select_q == GSS_MATCH && gate_polarity_q && !cnt_wr)
		|=> (count_o == $past(count_o) + 16'($past(match_pulse_o))))
		else $error("count outside match cycle");

	a_match_pol_zero: assert property (  // R06
		@(posedge core_clk_i) disable iff (!rstn_i)
		(gate_source_select_q == GSS_MATCH && !gate_polarity_q && !cnt_wr)
		|=> (count_o == $past(count_o) + 16'(!$past(match_pulse_o))))
		else $error("count not skipped on match");

	a_gate_advance: assert property (  // R10
		@(posedge core_clk_i) disable iff (!rstn_i)
		!cnt_wr |=> (count_o == $past(count_o) + 16'(gate_enable_o)))
		else $error("count ignores gate enable");

	a_ctrl_write: assert property (  // R01
		@(posedge core_clk_i) disable iff (!rstn_i)
		(rstn_i && wr_ctrl)
		|=> (gate_source_select_q == $past(wr_data_i[GSS_MSB:GSS_LSB])
		     && gate_polarity_q == $past(wr_data_i[GPOL_BIT])))
		else $error("gate control write lost");

	a_period_write: assert property (  // R03
		@(posedge core_clk_i) disable iff (!rstn_i)
		(rstn_i && wr_period) |=> (period_value_q == $past(wr_data_i)))
		else $error("period write lost");

	a_cnt_lo_write: assert property (  // R10
		@(posedge core_clk_i) disable iff (!rstn_i)
		(rstn_i && wr_cnt_lo)
		|=> (count_o == {$past(count_o[15:8]), $past(wr_data_i)}))
		else $error("low count byte write lost");

	a_cnt_hi_write: assert property (  // R10
		@(posedge core_clk_i) disable iff (!rstn_i)
		(rstn_i && wr_cnt_hi)
		|=> (count_o == {$past(wr_data_i), $past(count_o[7:0])}))
		else $error("high count byte write lost");

	a_pulse_at_wrap: assert property (  // R04
		@(posedge core_clk_i) disable iff (!rstn_i)
		match_pulse_o |-> (period_timer_count_q == 8'h00))
		else $error("match pulse away from wrap");

	a_rd_idle_zero: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		!$past(rd_i) |-> (rd_data_o == RST_RDATA))
		else $error("read data not cleared");

	a_rd_unmapped: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		($past(rd_i) && $past(addr_i) > OFS_CNT_HI)
		|-> (rd_data_o == RST_RDATA))
		else $error("unmapped read not zero");

	a_rd_ctrl_back: assert property (  // R02
		@(posedge core_clk_i) disable iff (!rstn_i)
		($past(rd_i) && $past(addr_i) == OFS_GATE_CTRL)
		|-> (rd_data_o[GPOL_BIT] == $past(gate_polarity_q) && rd_data_o[7] == 1'b0))
		else $error("control readback wrong");

	a_rd_cmp_one: assert property (  // R07
		@(posedge core_clk_i) disable iff (!rstn_i)
		($past(rd_i) && $past(addr_i) == OFS_CMP_STATUS && $past(rstn_i, 3))
		|-> (rd_data_o[CMP1_BIT] == $past(comparator_one_out_i, 3)))
		else $error("comparator one status wrong");

	a_rd_cmp_two: assert property (  // R08
		@(posedge core_clk_i) disable iff (!rstn_i)
		($past(rd_i) && $past(addr_i) == OFS_CMP_STATUS && $past(rstn_i, 3))
		|-> (rd_data_o[CMP2_BIT] == $past(comparator_two_out_i, 3)))
		else $error("comparator two status wrong");

	c_match_count: cover property (@(posedge core_clk_i) disable iff (!rstn_i)
		gate_source_select_q == GSS_MATCH && gate_polarity_q && match_pulse_o);
	c_pin_gate: cover property (@(posedge core_clk_i) disable iff (!rstn_i)
		gate_source_select_q == GSS_PIN && gate_en ##1 !gate_en_q);
	c_cmp_two: cover property (@(posedge core_clk_i) disable iff (!rstn_i)
		gate_source_select_q == GSS_CMP2 && $rose(cmp2_s2_q));
	c_timer_wrap: cover property (@(posedge core_clk_i) disable iff (!rstn_i)
		period_match ##1 match_pulse_o);
	c_match_skip: cover property (@(posedge core_clk_i) disable iff (!rstn_i)
		gate_source_select_q == GSS_MATCH && !gate_polarity_q && match_pulse_o);

endmodule // tgss_gate_timer

// ### sim/tgss_src_model.sv
// Far-side model: external gate pin and the two comparator outputs
`timescale 1ns/1ps
module tgss_src_model (
	input  wire logic       core_clk_i,
	input  wire logic [2:0] level_i,
	output logic            gate_input_pin_o,
	output logic            comparator_one_out_o,
	output logic            comparator_two_out_o
);
	initial {comparator_two_out_o, comparator_one_out_o, gate_input_pin_o} = 3'h0;
	// Levels move just after an edge, unrelated to bus traffic
	always @(posedge core_clk_i) begin
		{comparator_two_out_o, comparator_one_out_o, gate_input_pin_o} <= level_i;
	end
endmodule // tgss_src_model

// ### sim/timer_gate_source_select_tb.sv
// Self-checking bench for the gate source select timer
`timescale 1ns/1ps
module timer_gate_source_select_tb;
	import tgss_pkg::*;
	logic              core_clk_i = 1'b0;
	logic              rstn_i     = 1'b0;
	logic [ADDR_W-1:0] addr_i     = 4'h0;
	logic [DATA_W-1:0] wr_data_i  = 8'h00;
	logic              wr_i       = 1'b0;
	logic              rd_i       = 1'b0;
	logic [2:0]        level      = 3'h0;
	logic              pin, c_one, c_two, gate_enable_o, match_pulse_o;
	logic [DATA_W-1:0] rd_data_o;
	logic [CNT_W-1:0]  count_o, c0, cnt_prev;
	logic              chk_m = 1'b0, pol_m = 1'b0, mp_prev = 1'b0, pol, src;
	logic [1:0]        s;
	logic [7:0]        p;
	integer            seed = 65302, failures = 0, n_tests = 0, i, n;

	always #2.5 core_clk_i = ~core_clk_i;

	tgss_src_model i_tgss_src_model (.core_clk_i(core_clk_i), .level_i(level),
		.gate_input_pin_o(pin), .comparator_one_out_o(c_one), .comparator_two_out_o(c_two));
	tgss_gate_timer i_tgss_gate_timer (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
		.addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
		.gate_input_pin_i(pin), .comparator_one_out_i(c_one), .comparator_two_out_i(c_two),
		.rd_data_o(rd_data_o), .count_o(count_o), .gate_enable_o(gate_enable_o),
		.match_pulse_o(match_pulse_o));

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic gate_exp(input logic pl, input logic sr);
		return pl ? sr : !sr;
	endfunction

	task automatic check(input logic [CNT_W-1:0] seen, input logic [CNT_W-1:0] want);
		n_tests++;
		if (seen !== want) begin
			failures++;
			$display("wrong value at %0t: seen %0h expected %0h", $time, seen, want);
		end
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge core_clk_i);
		addr_i    <= a;
		wr_data_i <= d;
		wr_i      <= 1'b1;
		@(posedge core_clk_i);
		wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] want);
		@(posedge core_clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge core_clk_i);
		rd_i <= 1'b0;
		#1 check({8'h00, rd_data_o}, {8'h00, want});
	endtask

	task automatic wait_pulse();
		for (n = 0; n < 300 && match_pulse_o !== 1'b1; n++) begin
			@(posedge core_clk_i);
			#1;
		end
		if (n == 300) begin
			failures++;
			tally_and_finish();
		end
	endtask

	// Cycle monitor for the match source and the counter step
	always @(negedge core_clk_i) begin
		if (chk_m) begin
			check({15'h0000, gate_enable_o}, {15'h0000, gate_exp(pol_m, mp_prev)});
			check(count_o - cnt_prev, {15'h0000, gate_enable_o});
		end
		mp_prev  = match_pulse_o;
		cnt_prev = count_o;
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge core_clk_i);
		rstn_i <= 1'b1;
		rd(OFS_GATE_CTRL, 8'h00);
		rd(OFS_PERIOD, RST_PERIOD);
		rd(4'hF, 8'h00);
		wr(OFS_CMP_STATUS, 8'hC0);
		rd(OFS_CMP_STATUS, 8'h00);
		wr(OFS_GATE_CTRL, 8'hFF);
		rd(OFS_GATE_CTRL, 8'h43);
		// Gate closed: pin source, polarity one, pin low
		wr(OFS_GATE_CTRL, 8'h40);
		wr(OFS_CNT_LO, 8'hFE);
		wr(OFS_CNT_HI, 8'hA5);
		rd(OFS_CNT_LO, 8'hFE);
		rd(OFS_CNT_HI, 8'hA5);
		for (i = 0; i < 5; i++) begin
			p = (i == 0) ? 8'h00 : (8'($random(seed)) & 8'h0F);
			wr(OFS_PERIOD, p);
			rd(OFS_PERIOD, p);
			wait_pulse();
			@(posedge core_clk_i);
			#1 wait_pulse();
			check(16'(n + 1), {8'h00, p} + 16'h0001);
			rd(OFS_PER_COUNT, (p == 8'h00) ? 8'h00 : 8'h01);
		end
		wr(OFS_PERIOD, 8'h04);
		for (i = 0; i < 2; i++) begin
			pol_m = i[0];
			wr(OFS_GATE_CTRL, {1'b0, pol_m, 4'h0, GSS_MATCH});
			repeat (3) @(posedge core_clk_i);
			#1 chk_m = 1'b1;
			repeat (40) @(posedge core_clk_i);
			#1 chk_m = 1'b0;
		end
		for (i = 0; i < 24; i++) begin
			s     = (i % 3 == 0) ? GSS_PIN : ((i % 3 == 1) ? GSS_CMP1 : GSS_CMP2);
			pol   = (i < 6) ? (i >= 3) : 1'($random(seed));
			level <= 3'($random(seed));
			wr(OFS_GATE_CTRL, {1'b0, pol, 4'h0, s});
			repeat (6) @(posedge core_clk_i);
			rd(OFS_CMP_STATUS, {level[2], level[1], 6'h00});
			src = (s == GSS_PIN) ? level[0] : ((s == GSS_CMP1) ? level[1] : level[2]);
			c0  = count_o;
			repeat (8) @(posedge core_clk_i);
			#1 check({15'h0000, gate_enable_o}, {15'h0000, gate_exp(pol, src)});
			check(count_o - c0, gate_exp(pol, src) ? 16'h0008 : 16'h0000);
		end
		tally_and_finish();
	end
endmodule // timer_gate_source_select_tb
